// ---- fdmc_ctrl.sv ----
// Flash data memory command controller with program-update path.
// Assumes the core stalls on core_hold and the expanded RAM answers in one cycle.
module fdmc_ctrl #(
   parameter int PAGE_WRITE_CYCLES = fdmc_pkg::CYC_PAGE_WRITE,
   parameter int BYTE_WRITE_CYCLES = fdmc_pkg::CYC_BYTE_WRITE,
   parameter int ERASE_CYCLES = fdmc_pkg::CYC_ERASE,
   parameter int PROG_WRITE_CYCLES = fdmc_pkg::CYC_PROG_PAGE_WRITE
) (
   input wire logic core_clk,
   input wire logic resetn,
   input wire logic [3:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   output logic core_hold,
   output logic irq_block,
   output logic [7:0] expanded_ram_addr,
   input wire logic [7:0] expanded_ram_rdata
);
   typedef enum logic [2:0] {
      FDMC_IDLE, FDMC_RUN, FDMC_ERASE, FDMC_COPY, FDMC_WAIT
   } fdmc_state_t;

   fdmc_state_t state;
   logic [7:0] page_data_regs [4];
   logic [7:0] nv_addr_high;
   logic [7:0] nv_addr_low;
   logic [7:0] nv_command_reg;
   logic program_update;
   logic [7:0] op;
   logic [16:0] step;
   logic [16:0] step_last;
   logic [31:0] wait_cnt;
   logic mismatch;

   wire [15:0] nv_addr_pair = {nv_addr_high, nv_addr_low};
   wire cmd_wr = reg_wr && reg_addr == fdmc_pkg::ADDR_CMD && state == FDMC_IDLE;

   // Command validity per mode
   wire norm_cmd = reg_wdata == fdmc_pkg::PAGE_READ_CMD
      || reg_wdata == fdmc_pkg::PAGE_PROGRAM_CMD || reg_wdata == fdmc_pkg::PAGE_COMPARE_CMD
      || reg_wdata == fdmc_pkg::PAGE_ERASE_CMD || reg_wdata == fdmc_pkg::FULL_ERASE_CMD
      || reg_wdata == fdmc_pkg::SINGLE_READ_CMD || reg_wdata == fdmc_pkg::SINGLE_PROGRAM_CMD;
   wire upd_cmd = reg_wdata == fdmc_pkg::PAGE_PROGRAM_CMD
      || reg_wdata == fdmc_pkg::PAGE_ERASE_CMD || reg_wdata == fdmc_pkg::FULL_ERASE_CMD
      || reg_wdata == fdmc_pkg::SINGLE_PROGRAM_CMD;
   wire start_op = cmd_wr && (program_update ? upd_cmd : norm_cmd);

   // Data array address of a page or byte access
   wire [11:0] page_base = {nv_addr_pair[9:0], 2'b00};
   wire [11:0] byte_addr = nv_addr_pair[11:0];
   // Full erase sweeps only the user region; page erase is placed by the high byte and bits 7:6 of the low byte
   wire prog_in_range = program_update && (op == fdmc_pkg::SINGLE_PROGRAM_CMD
      ? nv_addr_pair <= fdmc_pkg::PROG_BYTE_LIMIT
      : op == fdmc_pkg::FULL_ERASE_CMD ? 1'b1
      : op == fdmc_pkg::PAGE_ERASE_CMD ? nv_addr_high < fdmc_pkg::PROG_PAGE_LIMIT
      : nv_addr_low < fdmc_pkg::PROG_PAGE_LIMIT);

   // Memory requests
   fdmc_pkg::fdmc_mem_req_t dreq;
   fdmc_pkg::fdmc_mem_req_t preq;
   logic [7:0] drdata;
   logic [7:0] prdata;
   wire [1:0] lane = step[1:0];
   wire single = op == fdmc_pkg::SINGLE_READ_CMD || op == fdmc_pkg::SINGLE_PROGRAM_CMD;
   wire [11:0] dword_addr = single ? byte_addr : page_base | {10'h000, lane};
   wire d_wr_page = op == fdmc_pkg::PAGE_PROGRAM_CMD
      || op == fdmc_pkg::SINGLE_PROGRAM_CMD;
   wire [7:0] d_wdata = single ? page_data_regs[0] : page_data_regs[lane];
   wire d_erase = state == FDMC_ERASE && !program_update;
   wire d_active = (state == FDMC_RUN && !program_update) || d_erase;
   wire [15:0] perase_base = {nv_addr_high, nv_addr_low[7:6], 6'h00};
   wire [15:0] pwr_base = {nv_addr_low, 8'h00};
   wire p_erase = state == FDMC_ERASE && program_update;
   wire p_copy = state == FDMC_COPY;
   wire p_byte = state == FDMC_RUN && program_update;
   wire [15:0] p_erase_addr = op == fdmc_pkg::FULL_ERASE_CMD ? step[15:0]
      : perase_base | {10'h000, step[5:0]};
   wire [15:0] p_copy_addr = pwr_base | {8'h00, expanded_ram_addr};

   assign dreq.wr = d_erase || (d_active && d_wr_page);
   assign dreq.addr = {4'h0, d_erase && op == fdmc_pkg::FULL_ERASE_CMD ? step[11:0]
      : dword_addr};
   assign dreq.wdata = d_erase ? fdmc_pkg::ERASED_BYTE : d_wdata;
   assign preq.wr = (p_erase || p_copy || p_byte) && prog_in_range;
   assign preq.addr = p_erase ? p_erase_addr : p_copy ? p_copy_addr : nv_addr_pair;
   assign preq.wdata = p_erase ? fdmc_pkg::ERASED_BYTE
      : p_copy ? expanded_ram_rdata : page_data_regs[0];

   fdmc_mem #(.DEPTH(fdmc_pkg::DATA_BYTES), .AW(12)) u_data (
      .core_clk(core_clk),
      .en(d_active),
      .req(dreq),
      .rdata(drdata)
   );
   fdmc_mem #(.DEPTH(fdmc_pkg::PROG_BYTES), .AW(16)) u_prog (
      .core_clk(core_clk),
      .en(preq.wr),
      .req(preq),
      .rdata(prdata)
   );

   // Step count of each sequence, then a dwell to the typical duration
   function automatic logic [16:0] steps_of(input logic [7:0] c, input logic upd);
      logic [16:0] s;
      s = 17'd4;
      if (c == fdmc_pkg::SINGLE_READ_CMD || c == fdmc_pkg::SINGLE_PROGRAM_CMD) begin
         s = 17'd1;
      end else if (c == fdmc_pkg::PAGE_ERASE_CMD) begin
         s = upd ? 17'(fdmc_pkg::PROG_ERASE_PAGE) : 17'd4;
      end else if (c == fdmc_pkg::FULL_ERASE_CMD) begin
         s = upd ? 17'(fdmc_pkg::PROG_BYTES) : 17'(fdmc_pkg::DATA_BYTES);
      end else if (c == fdmc_pkg::PAGE_PROGRAM_CMD && upd) begin
         s = 17'(fdmc_pkg::PROG_WRITE_PAGE);
      end
      return s;
   endfunction

   function automatic logic [31:0] dur_of(input logic [7:0] c, input logic upd);
      logic [31:0] d;
      d = 32'(fdmc_pkg::CYC_PAGE_READ);
      case (c)
         fdmc_pkg::SINGLE_READ_CMD: d = 32'(fdmc_pkg::CYC_BYTE_READ);
         fdmc_pkg::SINGLE_PROGRAM_CMD: d = 32'(BYTE_WRITE_CYCLES);
         fdmc_pkg::PAGE_ERASE_CMD: d = 32'(ERASE_CYCLES);
         fdmc_pkg::FULL_ERASE_CMD: d = 32'(ERASE_CYCLES);
         fdmc_pkg::PAGE_PROGRAM_CMD: d = upd ? 32'(PROG_WRITE_CYCLES)
            : 32'(PAGE_WRITE_CYCLES);
         default: d = 32'(fdmc_pkg::CYC_PAGE_READ);
      endcase
      return d;
   endfunction

   wire is_erase = reg_wdata == fdmc_pkg::PAGE_ERASE_CMD
      || reg_wdata == fdmc_pkg::FULL_ERASE_CMD;
   wire is_copy = program_update && reg_wdata == fdmc_pkg::PAGE_PROGRAM_CMD;
   wire step_done = step == step_last;
   wire is_read_op = op == fdmc_pkg::PAGE_READ_CMD || op == fdmc_pkg::SINGLE_READ_CMD;

   // Sequencer
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         state <= FDMC_IDLE;
         op <= fdmc_pkg::RESET_BYTE;
         step <= '0;
         step_last <= '0;
         wait_cnt <= '0;
      end else begin
         case (state)
            FDMC_IDLE: begin
               step <= '0;
               if (start_op) begin
                  op <= reg_wdata;
                  step_last <= steps_of(reg_wdata, program_update) - 17'd1;
                  wait_cnt <= dur_of(reg_wdata, program_update);
                  state <= is_erase ? FDMC_ERASE : is_copy ? FDMC_COPY : FDMC_RUN;
               end
            end
            FDMC_RUN, FDMC_ERASE, FDMC_COPY: begin
               // Saturates so a long sweep simply outlasts the dwell
               if (wait_cnt != 32'd0) begin
                  wait_cnt <= wait_cnt - 32'd1;
               end
               step <= step + 17'd1;
               if (step_done) begin
                  state <= FDMC_WAIT;
               end
            end
            FDMC_WAIT: begin
               if (wait_cnt != 32'd0) begin
                  wait_cnt <= wait_cnt - 32'd1;
               end
               if (wait_cnt <= 32'd1) begin
                  state <= FDMC_IDLE;
               end
            end
            default: state <= FDMC_IDLE;
         endcase
      end
   end

   assign expanded_ram_addr = step[7:0];
   assign core_hold = state != FDMC_IDLE;
   assign irq_block = core_hold;

   // Captured read data lands one cycle after the array read
   logic cap_pend;
   logic [1:0] cap_idx;
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         cap_pend <= 1'b0;
         cap_idx <= 2'd0;
      end else begin
         cap_pend <= state == FDMC_RUN && !program_update;
         cap_idx <= single ? 2'd0 : lane;
      end
   end

   // Software-visible registers
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         for (int i = 0; i < 4; i++) begin
            page_data_regs[i] <= fdmc_pkg::RESET_BYTE;
         end
         nv_addr_high <= fdmc_pkg::RESET_BYTE;
         nv_addr_low <= fdmc_pkg::RESET_BYTE;
         nv_command_reg <= fdmc_pkg::RESET_BYTE;
         program_update <= 1'b0;
         mismatch <= 1'b0;
      end else begin
         if (reg_wr && state == FDMC_IDLE) begin
            if (reg_addr <= fdmc_pkg::ADDR_DATA3) begin
               page_data_regs[reg_addr[1:0]] <= reg_wdata;
            end
            if (reg_addr == fdmc_pkg::ADDR_HIGH) begin
               nv_addr_high <= reg_wdata;
            end
            if (reg_addr == fdmc_pkg::ADDR_LOW) begin
               nv_addr_low <= reg_wdata;
            end
         end
         if (cmd_wr) begin
            nv_command_reg <= reg_wdata;
            mismatch <= 1'b0;
            if (reg_wdata == fdmc_pkg::PROGRAM_UPDATE_MODE) begin
               program_update <= 1'b1;
            end
            if (reg_wdata == fdmc_pkg::LEAVE_PROGRAM_UPDATE) begin
               program_update <= 1'b0;
            end
         end
         if (cap_pend && is_read_op) begin
            page_data_regs[cap_idx] <= drdata;
         end
         if (cap_pend && op == fdmc_pkg::PAGE_COMPARE_CMD
               && drdata != page_data_regs[cap_idx]) begin
            mismatch <= 1'b1;
         end
      end
   end

   // Compare result replaces the command code on read back
   wire is_cmp = nv_command_reg == fdmc_pkg::PAGE_COMPARE_CMD && !program_update;
   wire [7:0] cmd_view = is_cmp ? (mismatch ? fdmc_pkg::VERIFY_FAIL
      : fdmc_pkg::RESET_BYTE) : nv_command_reg;
   wire [7:0] rd_mux = reg_addr <= fdmc_pkg::ADDR_DATA3 ? page_data_regs[reg_addr[1:0]]
      : reg_addr == fdmc_pkg::ADDR_HIGH ? nv_addr_high
      : reg_addr == fdmc_pkg::ADDR_LOW ? nv_addr_low
      : reg_addr == fdmc_pkg::ADDR_CMD ? cmd_view
      : reg_addr == fdmc_pkg::ADDR_MODE ? {7'h00, program_update} : 8'h00;

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         reg_rdata <= fdmc_pkg::RESET_BYTE;
      end else begin
         reg_rdata <= reg_rd ? rd_mux : fdmc_pkg::RESET_BYTE;
      end
   end

   a_hold_start: assert property (@(posedge core_clk) disable iff (!resetn)
      start_op |=> core_hold)
      else $error("hold did not follow a command");
   a_bad_no_stall: assert property (@(posedge core_clk) disable iff (!resetn)
      (cmd_wr && !start_op) |=> !core_hold)
      else $error("undefined command stalled");
   a_read_time: assert property (@(posedge core_clk) disable iff (!resetn)
      (start_op && !program_update && reg_wdata == fdmc_pkg::SINGLE_READ_CMD)
      |=> core_hold [*8] ##1 core_hold [*2] ##1 !core_hold)
      else $error("single read duration wrong");
   a_irq_hold: assert property (@(posedge core_clk) disable iff (!resetn)
      irq_block == core_hold)
      else $error("interrupt block differs from hold");
   a_enter_upd: assert property (@(posedge core_clk) disable iff (!resetn)
      (cmd_wr && reg_wdata == fdmc_pkg::PROGRAM_UPDATE_MODE) |=> program_update)
      else $error("update mode not entered");
   a_upd_noread: assert property (@(posedge core_clk) disable iff (!resetn)
      (cmd_wr && program_update && reg_wdata == fdmc_pkg::PAGE_READ_CMD)
      |=> !core_hold)
      else $error("update mode read ran");
   a_prog_limit: assert property (@(posedge core_clk) disable iff (!resetn)
      preq.wr |-> preq.addr <= fdmc_pkg::PROG_BYTE_LIMIT)
      else $error("write above user program region");
   a_rdata_idle: assert property (@(posedge core_clk) disable iff (!resetn)
      !reg_rd |=> reg_rdata == 8'h00)
      else $error("read data outside read slot");
endmodule

// ---- fdmc_expanded_ram_model.sv ----
// Expanded RAM model feeding the update-mode page copy.
// Assumes a combinational read, answered in the cycle of the address.
module fdmc_expanded_ram_model (
   input wire logic [7:0] expanded_ram_addr,
   output logic [7:0] expanded_ram_rdata
);
   // Pattern that differs per byte so a wrong copy order shows
   assign expanded_ram_rdata = expanded_ram_addr ^ 8'hA5;
endmodule

// ---- fdmc_mem.sv ----
// Byte-wide array with registered read data.
// Assumes one access per cycle from the sequencer.
module fdmc_mem #(
   parameter int DEPTH = 4096,
   parameter int AW = 12
) (
   input wire logic core_clk,
   input wire logic en,
   input wire fdmc_pkg::fdmc_mem_req_t req,
   output logic [7:0] rdata
);
   logic [7:0] mem [DEPTH];
   wire [AW-1:0] idx = req.addr[AW-1:0];
   always_ff @(posedge core_clk) begin
      if (en) begin
         if (req.wr) begin
            mem[idx] <= req.wdata;
         end
         rdata <= mem[idx];
      end
   end
endmodule

// ---- fdmc_pkg.sv ----
// Constants and carrier types for the flash data memory command controller.
// Assumes a 250 MHz core clock; the write and erase counts derive from it, the read counts are fixed machine cycles.
package fdmc_pkg;
   localparam int CLK_MHZ = 250;
   localparam int MACHINE_CYCLES_PAGE_READ = 25;
   localparam int MACHINE_CYCLES_BYTE_READ = 10;
   localparam int PAGE_WRITE_US = 380;
   localparam int BYTE_WRITE_US = 200;
   localparam int ERASE_MS = 2;
   localparam int PROG_PAGE_WRITE_MS = 15;
   localparam int CYC_PAGE_READ = MACHINE_CYCLES_PAGE_READ;
   localparam int CYC_BYTE_READ = MACHINE_CYCLES_BYTE_READ;
   localparam int CYC_PAGE_WRITE = PAGE_WRITE_US * CLK_MHZ;
   localparam int CYC_BYTE_WRITE = BYTE_WRITE_US * CLK_MHZ;
   localparam int CYC_ERASE = ERASE_MS * 1000 * CLK_MHZ;
   localparam int CYC_PROG_PAGE_WRITE = PROG_PAGE_WRITE_MS * 1000 * CLK_MHZ;
   localparam int DATA_PAGES = 1024;
   localparam int DATA_BYTES = 4096;
   localparam int PROG_BYTES = 57344;
   localparam int PROG_ERASE_PAGE = 64;
   localparam int PROG_WRITE_PAGE = 256;
   localparam logic [7:0] PROG_PAGE_LIMIT = 8'hE0;
   localparam logic [15:0] DATA_BYTE_LIMIT = 16'h0FFF;
   localparam logic [15:0] PROG_BYTE_LIMIT = 16'hDFFF;
   localparam logic [7:0] ERASED_BYTE = 8'hFF;
   localparam logic [7:0] RESET_BYTE = 8'h00;
   localparam logic [7:0] VERIFY_FAIL = 8'h01;
   localparam logic [3:0] ADDR_DATA0 = 4'h0;
   localparam logic [3:0] ADDR_DATA1 = 4'h1;
   localparam logic [3:0] ADDR_DATA2 = 4'h2;
   localparam logic [3:0] ADDR_DATA3 = 4'h3;
   localparam logic [3:0] ADDR_HIGH = 4'h4;
   localparam logic [3:0] ADDR_LOW = 4'h5;
   localparam logic [3:0] ADDR_CMD = 4'h6;
   localparam logic [3:0] ADDR_MODE = 4'h7;
   localparam logic [7:0] PAGE_READ_CMD = 8'h01;
   localparam logic [7:0] PAGE_PROGRAM_CMD = 8'h02;
   localparam logic [7:0] PAGE_COMPARE_CMD = 8'h04;
   localparam logic [7:0] PAGE_ERASE_CMD = 8'h05;
   localparam logic [7:0] FULL_ERASE_CMD = 8'h06;
   localparam logic [7:0] LEAVE_PROGRAM_UPDATE = 8'h0F;
   localparam logic [7:0] SINGLE_READ_CMD = 8'h81;
   localparam logic [7:0] SINGLE_PROGRAM_CMD = 8'h82;
   localparam logic [7:0] PROGRAM_UPDATE_MODE = 8'hF0;
   typedef struct packed {
      logic wr;
      logic [15:0] addr;
      logic [7:0] wdata;
   } fdmc_mem_req_t;
endpackage

// ---- tb.sv ----
// Self-checking bench for the flash data memory command controller.
// Assumes shortened write and erase counts and a combinational expanded RAM model.
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int PW = 20;
   localparam int BW = 12;
   localparam int ER = 80;
   logic core_clk = 1'b0;
   logic resetn = 1'b0;
   logic [3:0] reg_addr = 4'h0;
   logic [7:0] reg_wdata = 8'h00;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [7:0] reg_rdata;
   logic core_hold;
   logic irq_block;
   logic [7:0] expanded_ram_addr;
   logic [7:0] expanded_ram_rdata;
   logic [31:0] seed = 32'h00000029;
   logic [7:0] exp_q[$];
   int hold_q[$];
   int bad_count = 0;
   int check_count = 0;
   int hold_cnt = 0;
   logic rd_seen = 1'b0;
   logic [7:0] pg[4];
   logic [9:0] page;
   logic [7:0] noop[3] = '{8'h01, 8'h81, 8'h04};

   fdmc_ctrl #(.PAGE_WRITE_CYCLES(PW), .BYTE_WRITE_CYCLES(BW), .ERASE_CYCLES(ER),
      .PROG_WRITE_CYCLES(300)) i_fdmc_ctrl (.core_clk(core_clk), .resetn(resetn),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .core_hold(core_hold), .irq_block(irq_block),
      .expanded_ram_addr(expanded_ram_addr), .expanded_ram_rdata(expanded_ram_rdata));
   fdmc_expanded_ram_model i_fdmc_expanded_ram_model (.expanded_ram_addr(expanded_ram_addr), .expanded_ram_rdata(expanded_ram_rdata));

   initial begin
      forever #2 core_clk = ~core_clk;
   end

   function automatic logic [31:0] xs(input logic [31:0] v);
      logic [31:0] r;
      r = v ^ (v << 13);
      r = r ^ (r >> 17);
      return r ^ (r << 5);
   endfunction

   task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
      check_count++;
      if (got !== exp) begin
         bad_count++;
         $display("wrong value at %0t: read %h expected %h", $time, got, exp);
      end
   endtask

   task automatic cmp_hold(input int got, input int exp);
      check_count++;
      if (got != exp) begin
         bad_count++;
         $display("wrong value at %0t: hold %0d expected %0d", $time, got, exp);
      end
   endtask

   task automatic cmp_bit(input logic got, input logic exp);
      check_count++;
      if (got !== exp) begin
         bad_count++;
         $display("wrong value at %0t: flag %b expected %b", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge core_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask

   task automatic rd(input logic [3:0] a, input logic [7:0] e);
      @(posedge core_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      exp_q.push_back(e);
      @(posedge core_clk);
      reg_rd <= 1'b0;
   endtask

   task automatic set_addr(input logic [15:0] a);
      wr(fdmc_pkg::ADDR_HIGH, a[15:8]);
      wr(fdmc_pkg::ADDR_LOW, a[7:0]);
   endtask

   // Hold 0: no stall expected; -1: length not checked; -3: not watched
   task automatic cmd(input logic [7:0] c, input int hold, input logic poke);
      int n;
      wr(fdmc_pkg::ADDR_CMD, c);
      if (hold > 0 || hold == -1) hold_q.push_back(hold);
      if (poke) wr(fdmc_pkg::ADDR_DATA1, 8'h5A);
      @(posedge core_clk);
      if (hold == 0) cmp_bit(core_hold, 1'b0);
      n = 0;
      while (core_hold !== 1'b0 && n < 10000) begin
         @(posedge core_clk);
         n++;
      end
      cmp_bit(core_hold, 1'b0);
   endtask

   // Result watcher: read data, hold lengths, blocked interrupts
   always @(posedge core_clk) begin
      if (rd_seen && exp_q.size() > 0) cmp_byte(reg_rdata, exp_q.pop_front());
      rd_seen <= reg_rd;
      if (resetn === 1'b1) cmp_bit(irq_block, core_hold);
      if (core_hold === 1'b1) begin
         hold_cnt <= hold_cnt + 1;
      end else if (hold_cnt > 0) begin
         if (hold_q.size() > 0 && hold_q[0] >= 0) cmp_hold(hold_cnt, hold_q[0]);
         if (hold_q.size() > 0) void'(hold_q.pop_front());
         hold_cnt <= 0;
      end
   end

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   initial begin
      repeat (40000) @(posedge core_clk);
      bad_count++;
      print_verdict();
   end

   initial begin
      repeat (12) @(posedge core_clk);
      resetn <= 1'b1;
      rd(fdmc_pkg::ADDR_MODE, 8'h00);
      rd(fdmc_pkg::ADDR_CMD, 8'h00);
      $display("test reset done");
      cmd(fdmc_pkg::FULL_ERASE_CMD, -1, 1'b0);
      seed = xs(seed);
      page = seed[9:0];
      set_addr({6'h00, page});
      cmd(fdmc_pkg::PAGE_READ_CMD, 25, 1'b0);
      for (int j = 0; j < 4; j++) rd(4'(j), 8'hFF);
      for (int j = 0; j < 4; j++) begin
         seed = xs(seed);
         pg[j] = seed[7:0];
         wr(4'(j), pg[j]);
      end
      cmd(fdmc_pkg::PAGE_PROGRAM_CMD, PW, 1'b0);
      for (int j = 0; j < 4; j++) wr(4'(j), 8'h00);
      cmd(fdmc_pkg::PAGE_READ_CMD, 25, 1'b0);
      for (int j = 0; j < 4; j++) rd(4'(j), pg[j]);
      cmd(fdmc_pkg::PAGE_COMPARE_CMD, 25, 1'b0);
      rd(fdmc_pkg::ADDR_CMD, 8'h00);
      wr(fdmc_pkg::ADDR_DATA0, ~pg[0]);
      cmd(fdmc_pkg::PAGE_COMPARE_CMD, 25, 1'b0);
      rd(fdmc_pkg::ADDR_CMD, fdmc_pkg::VERIFY_FAIL);
      $display("test page program done");
      set_addr({4'h0, page, 2'b10});
      cmd(fdmc_pkg::SINGLE_READ_CMD, 10, 1'b0);
      rd(fdmc_pkg::ADDR_DATA0, pg[2]);
      set_addr({4'h0, page + 10'h001, 2'b01});
      wr(fdmc_pkg::ADDR_DATA0, pg[3]);
      cmd(fdmc_pkg::SINGLE_PROGRAM_CMD, BW, 1'b0);
      wr(fdmc_pkg::ADDR_DATA0, 8'h00);
      cmd(fdmc_pkg::SINGLE_READ_CMD, 10, 1'b0);
      rd(fdmc_pkg::ADDR_DATA0, pg[3]);
      $display("test byte access done");
      set_addr({6'h00, page});
      cmd(fdmc_pkg::PAGE_ERASE_CMD, ER, 1'b1);
      rd(fdmc_pkg::ADDR_DATA1, pg[1]);
      cmd(fdmc_pkg::PAGE_READ_CMD, 25, 1'b0);
      for (int j = 0; j < 4; j++) rd(4'(j), 8'hFF);
      cmd(8'h03, 0, 1'b0);
      rd(fdmc_pkg::ADDR_CMD, 8'h03);
      $display("test erase and refusal done");
      cmd(fdmc_pkg::PROGRAM_UPDATE_MODE, -3, 1'b0);
      rd(fdmc_pkg::ADDR_MODE, 8'h01);
      wr(fdmc_pkg::ADDR_DATA0, 8'hC3);
      for (int j = 0; j < 3; j++) cmd(noop[j], 0, 1'b0);
      rd(fdmc_pkg::ADDR_DATA0, 8'hC3);
      set_addr(16'h1234);
      cmd(fdmc_pkg::SINGLE_PROGRAM_CMD, BW, 1'b0);
      set_addr(16'h0080);
      cmd(fdmc_pkg::PAGE_ERASE_CMD, ER, 1'b0);
      set_addr(16'h0010);
      cmd(fdmc_pkg::PAGE_PROGRAM_CMD, 300, 1'b0);
      cmd(fdmc_pkg::LEAVE_PROGRAM_UPDATE, -3, 1'b0);
      rd(fdmc_pkg::ADDR_MODE, 8'h00);
      repeat (3) @(posedge core_clk);
      $display("test update mode done");
      print_verdict();
   end
endmodule
